/* ucmo_pkg.sv */
package ucmo_pkg;

  localparam int ADDR_W = 32;
  localparam int OFS_W = 9;

  // Cache select codes from the instruction word
  localparam logic [1:0] CSEL_I = 2'h0;
  localparam logic [1:0] CSEL_D = 2'h1;
  localparam logic [1:0] CSEL_T = 2'h2;
  localparam logic [1:0] CSEL_S = 2'h3;

  // Operation codes
  localparam logic [2:0] OP_IDX_INV = 3'h0;
  localparam logic [2:0] OP_LD_TAG = 3'h1;
  localparam logic [2:0] OP_ST_TAG = 3'h2;

  localparam logic [1:0] RST_SYNC_INIT = 2'h0;

  typedef enum logic [1:0] {
    SEG_KERNEL_ONLY = 2'h0,
    UNMAPPED_USER_SEGMENT_MODE = 2'h1,
    MAPPED_USER_SUPERVISOR_SEGMENT_MODE = 2'h2,
    MAPPED_USER_KERNEL_SEGMENT_MODE = 2'h3
  } ucmo_seg_type;

  typedef enum logic [3:0] {
    EXC_NONE = 4'h0,
    EXC_TRANS_REFILL = 4'h1,
    EXC_TRANS_INVALID = 4'h2,
    EXC_COP_UNUSABLE = 4'h3,
    EXC_RESERVED_INSTR = 4'h4,
    EXC_ADDR_ERR = 4'h5,
    EXC_CACHE_ERR = 4'h6,
    EXC_BUS_ERR = 4'h7
  } ucmo_exc_type;

  typedef enum logic [1:0] {
    CMD_IDLE = 2'h0,
    CMD_READ_TAG = 2'h1,
    CMD_INVALIDATE = 2'h2,
    CMD_PASS_OP = 2'h3
  } ucmo_cmd_type;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_XLAT = 6'h02,
    ST_SETUP = 6'h04,
    ST_LOOK = 6'h08,
    ST_WB = 6'h10,
    ST_ISSUE = 6'h20
  } ucmo_state_type;

endpackage : ucmo_pkg

/* ucmo_cache_op.sv */
`timescale 1ns/1ps
// Notes on behaviour
// R01 - Effective address: base plus sign-extended offset
// R02 - Bits 17:16 pick I, D, T, S
// R03 - Bits 20:18 pick the operation
// R04 - Virtual cache addressed by effective address
// R05 - Physical cache addressed by translated address
// R06 - Way and index split from address bits
// R07 - Direct-mapped cache ignores the way field
// R08 - Translation faults report load-type cause
// R09 - Never store-type, modified or inhibit faults
// R10 - Any alignment accepted, no alignment fault
// R11 - Writeback cache or bus error: cache error
// R12 - Bus transaction error may raise bus error
// R13 - Load/store tag never raise cache error
// R14 - Kernel region fault may raise address error
// R15 - Completion waits like a memory barrier
// R16 - Inclusive caches: inner level handled first
// R17 - Coherent attribute hit ops are broadcast
// R18 - All affected levels broadcast alike
// R19 - User-mapped segments translate via user mapping
// R20 - Exists only when config field is one
// R21 - Dirty line written back, then invalidated
// R22 - Software converts index to unmapped address
// R23 - Software follows writebacks with a barrier
// R24 - Coprocessor unusable outside user-accessible segments
// R25 - Unimplemented combinations need no defined result
// R26 - One exception; abort leaves caches untouched
module ucmo_cache_op
  import ucmo_pkg::*;
#(
  parameter bit INCLUSIVE = 1'b1,
  parameter bit ADDR_ERR_EN = 1'b1,
  parameter bit INDEX_USE_VADDR = 1'b1,
  parameter logic [3:0] VIRT_MASK = 4'h0,
  parameter logic [3:0] WB_MASK = 4'hE,
  parameter int WAY_W = 3,
  parameter int IDX_W = 14,
  parameter int OFF_BIT [4] = '{5, 5, 6, 6},
  parameter int IDX_BIT [4] = '{13, 13, 17, 18},
  parameter int WAY_BITS [4] = '{2, 2, 3, 3}
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pipeline request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [2:0] req_op,
  input wire logic [1:0] req_cache,
  input wire logic [ADDR_W-1:0] req_base,
  input wire logic [OFS_W-1:0] req_offset,
  // Configuration
  input wire logic extended_vaddr_config_field,
  input wire logic system_control_coprocessor_en,
  // Completion
  output logic done,
  output logic exc_valid,
  output ucmo_exc_type exc_kind,
  output logic load_translation_cause,
  output logic load_address_error_cause,
  output logic store_translation_cause,
  // Translation unit
  output logic xlat_req,
  output logic xlat_user_map,
  output logic [ADDR_W-1:0] xlat_vaddr,
  input wire logic xlat_ack,
  input wire logic [ADDR_W-1:0] xlat_paddr,
  input wire logic xlat_refill,
  input wire logic xlat_invalid,
  input wire logic [1:0] xlat_seg_mode,
  input wire logic xlat_kernel_fault,
  input wire logic cacheability_attribute_coherent,
  // Cache arrays
  output logic cache_req,
  output ucmo_cmd_type cache_cmd,
  output logic [1:0] cache_sel,
  output logic [2:0] cache_op,
  output logic [WAY_W-1:0] cache_way,
  output logic [IDX_W-1:0] cache_index,
  output logic [ADDR_W-1:0] cache_addr,
  output logic cache_bcast,
  input wire logic cache_ack,
  input wire logic cache_err,
  input wire logic cache_bus_err,
  input wire logic cache_line_valid,
  input wire logic cache_line_dirty,
  input wire logic [ADDR_W-1:0] cache_tag_addr,
  // Writeback bus
  output logic wb_req,
  output logic [ADDR_W-1:0] wb_addr,
  input wire logic wb_ack,
  input wire logic wb_err
);

  typedef struct packed {
    ucmo_state_type state;
    logic [2:0] op;
    logic [1:0] tgt;
    logic [1:0] lvl;
    logic [ADDR_W-1:0] vaddr;
    logic [ADDR_W-1:0] paddr;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] wb_addr;
    logic [WAY_W-1:0] way;
    logic [IDX_W-1:0] idx;
    logic bcast;
    logic done;
    ucmo_exc_type exc;
    logic ld_tr;
    logic ld_ae;
  } ucmo_regs_type;

  ucmo_regs_type st_q;
  ucmo_regs_type st_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [ADDR_W-1:0] eff_addr;
  logic tag_op;

  // Bits [hi..lo] of an address, n bits wide; n of zero yields zero
  function automatic logic [ADDR_W-1:0] addr_field(
    input logic [ADDR_W-1:0] a,
    input int lo,
    input int n
  );
    addr_field = (a >> lo) & ~({ADDR_W{1'b1}} << n);
  endfunction : addr_field

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= RST_SYNC_INIT;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign eff_addr = req_base +
    {{(ADDR_W-OFS_W){req_offset[OFS_W-1]}}, req_offset}; // R01 R10
  // Diagnostic tag ops must not report cache errors
  assign tag_op = (st_q.op == OP_LD_TAG) || (st_q.op == OP_ST_TAG);

  always_comb begin
    logic [ADDR_W-1:0] a;
    logic [ADDR_W-1:0] fw;
    logic [ADDR_W-1:0] fi;
    a = '0;
    fw = '0;
    fi = '0;
    st_d = st_q;
    st_d.done = 1'b0;
    st_d.exc = EXC_NONE;
    st_d.ld_tr = 1'b0;
    st_d.ld_ae = 1'b0;
    case (st_q.state)
      ST_IDLE: begin
        if (req_valid) begin
          st_d.op = req_op; // R03
          st_d.tgt = req_cache; // R02
          // Inner level first when outer levels include it
          if (INCLUSIVE && (req_cache == CSEL_S || req_cache == CSEL_T)) begin
            st_d.lvl = CSEL_D; // R16
          end else begin
            st_d.lvl = req_cache; // R02
          end
          st_d.vaddr = eff_addr; // R01
          if (!extended_vaddr_config_field) begin
            st_d.done = 1'b1; // R20
            st_d.exc = EXC_RESERVED_INSTR; // R20
          end else if (!system_control_coprocessor_en) begin
            st_d.done = 1'b1;
            st_d.exc = EXC_COP_UNUSABLE; // R24
          end else begin
            st_d.state = ST_XLAT;
          end
        end
      end
      ST_XLAT: begin
        if (xlat_ack) begin
          st_d.paddr = xlat_paddr; // R05
          // One decision for every level the op touches
          st_d.bcast = cacheability_attribute_coherent && st_q.op[2]; // R17 R18
          st_d.state = ST_IDLE;
          st_d.done = 1'b1;
          // Priority keeps it to a single exception; no cache touched
          if (xlat_seg_mode == SEG_KERNEL_ONLY) begin
            st_d.exc = EXC_COP_UNUSABLE; // R24 R26
          end else if (ADDR_ERR_EN && xlat_kernel_fault) begin
            st_d.exc = EXC_ADDR_ERR; // R14
            st_d.ld_ae = 1'b1; // R14
          end else if (xlat_refill) begin
            st_d.exc = EXC_TRANS_REFILL; // R08 R09
            st_d.ld_tr = 1'b1; // R08
          end else if (xlat_invalid) begin
            st_d.exc = EXC_TRANS_INVALID; // R08 R09
            st_d.ld_tr = 1'b1; // R08
          end else begin
            st_d.state = ST_SETUP;
            st_d.done = 1'b0;
          end
        end
      end
      ST_SETUP: begin
        if (!st_q.op[2]) begin
          a = INDEX_USE_VADDR ? st_q.vaddr : st_q.paddr;
        end else if (VIRT_MASK[st_q.lvl]) begin
          a = st_q.vaddr; // R04
        end else begin
          a = st_q.paddr; // R05
        end
        fw = addr_field(a, IDX_BIT[st_q.lvl], WAY_BITS[st_q.lvl]); // R06 R07
        fi = addr_field(a, OFF_BIT[st_q.lvl],
          IDX_BIT[st_q.lvl] - OFF_BIT[st_q.lvl]); // R06
        st_d.addr = a;
        st_d.way = fw[WAY_W-1:0];
        st_d.idx = fi[IDX_W-1:0];
        // Only write-back levels need the tag looked at first
        if (st_q.op == OP_IDX_INV && WB_MASK[st_q.lvl]) begin
          st_d.state = ST_LOOK; // R21
        end else begin
          st_d.state = ST_ISSUE; // R25
        end
      end
      ST_LOOK: begin
        if (cache_ack) begin
          if (cache_err) begin
            st_d.state = ST_IDLE;
            st_d.done = 1'b1;
            st_d.exc = EXC_CACHE_ERR; // R11
          end else if (cache_line_valid && cache_line_dirty) begin
            st_d.wb_addr = cache_tag_addr; // R21
            st_d.state = ST_WB; // R21
          end else begin
            st_d.state = ST_ISSUE; // R21
          end
        end
      end
      ST_WB: begin
        if (wb_ack) begin
          if (wb_err) begin
            st_d.state = ST_IDLE;
            st_d.done = 1'b1;
            st_d.exc = EXC_CACHE_ERR; // R11
          end else begin
            st_d.state = ST_ISSUE; // R15 R21
          end
        end
      end
      ST_ISSUE: begin
        if (cache_ack) begin
          if (cache_bus_err) begin
            st_d.state = ST_IDLE;
            st_d.done = 1'b1;
            st_d.exc = EXC_BUS_ERR; // R12
          end else if (cache_err && !tag_op) begin
            st_d.state = ST_IDLE;
            st_d.done = 1'b1;
            st_d.exc = EXC_CACHE_ERR; // R13
          end else if (st_q.lvl == st_q.tgt) begin
            st_d.state = ST_IDLE;
            st_d.done = 1'b1; // R15
          end else begin
            st_d.lvl = (st_q.lvl == CSEL_D) ? CSEL_S : CSEL_T; // R16
            st_d.state = ST_SETUP;
          end
        end
      end
      default: begin
        st_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{state: ST_IDLE, exc: EXC_NONE, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign req_ready = (st_q.state == ST_IDLE);
  assign done = st_q.done;
  assign exc_valid = st_q.done && (st_q.exc != EXC_NONE); // R26
  assign exc_kind = st_q.exc;
  assign load_translation_cause = st_q.ld_tr;
  assign load_address_error_cause = st_q.ld_ae;
  assign store_translation_cause = 1'b0; // R09

  // User mapping asked for; the unit applies it to user-mapped kernel mode
  assign xlat_req = (st_q.state == ST_XLAT);
  assign xlat_user_map = (st_q.state == ST_XLAT); // R19
  assign xlat_vaddr = st_q.vaddr;

  assign cache_req = (st_q.state == ST_LOOK) || (st_q.state == ST_ISSUE);
  always_comb begin
    cache_cmd = CMD_IDLE;
    if (st_q.state == ST_LOOK) begin
      cache_cmd = CMD_READ_TAG;
    end else if (st_q.state == ST_ISSUE) begin
      cache_cmd = (st_q.op == OP_IDX_INV) ? CMD_INVALIDATE : CMD_PASS_OP;
    end
  end
  assign cache_sel = st_q.lvl;
  assign cache_op = st_q.op;
  assign cache_way = st_q.way;
  assign cache_index = st_q.idx;
  assign cache_addr = st_q.addr;
  assign cache_bcast = st_q.bcast;

  assign wb_req = (st_q.state == ST_WB);
  assign wb_addr = st_q.wb_addr;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_dirty_hit;
    st_q.state == ST_LOOK && cache_ack && !cache_err &&
      cache_line_valid && cache_line_dirty;
  endsequence

  sequence s_wb_then_inv;
    wb_req && wb_addr == $past(cache_tag_addr);
  endsequence

  chk_ea_formed: assert property ( // R01
    req_ready && req_valid && extended_vaddr_config_field &&
      system_control_coprocessor_en |=>
      xlat_req && xlat_vaddr == $past(req_base + ADDR_W'($signed(req_offset))))
    else $error("effective address wrong");

  chk_trans_cause: assert property ( // R08
    exc_valid && (exc_kind == EXC_TRANS_REFILL ||
      exc_kind == EXC_TRANS_INVALID) |->
      load_translation_cause && !store_translation_cause)
    else $error("translation fault without load cause");

  chk_direct_way: assert property ( // R07
    cache_req && WAY_BITS[cache_sel] == 0 |-> cache_way == '0)
    else $error("way used on direct-mapped cache");

  chk_dirty_wb: assert property ( // R21
    s_dirty_hit |=> s_wb_then_inv)
    else $error("dirty line not written back to tag address");

  chk_no_tag_err: assert property ( // R13
    st_q.state == ST_ISSUE && cache_ack && tag_op && !cache_bus_err |=>
      exc_kind != EXC_CACHE_ERR)
    else $error("tag op raised cache error");

  chk_wb_err: assert property ( // R11
    wb_req && wb_ack && wb_err |=> exc_valid && exc_kind == EXC_CACHE_ERR)
    else $error("writeback error not a cache error");

  chk_abort_xlat: assert property ( // R26
    xlat_req && xlat_ack && xlat_refill |=>
      exc_valid && !cache_req ##1 req_ready && !done)
    else $error("translation fault did not abort");

  chk_reserved: assert property ( // R20
    req_ready && req_valid && !extended_vaddr_config_field |=>
      exc_valid && exc_kind == EXC_RESERVED_INSTR && !xlat_req)
    else $error("instruction ran without config field");

endmodule : ucmo_cache_op

/* ucmo_far_model.sv */
`timescale 1ns/1ps
module ucmo_far_model
  import ucmo_pkg::*;
#(
  parameter logic [31:0] TAG = 32'h0012_34C0
) (
  // Clock, reset and fault plan
  input wire logic clk,
  input wire logic nrst,
  input wire logic [9:0] flt,
  // Translation unit
  input wire logic xlat_req,
  input wire logic [31:0] xlat_vaddr,
  output logic xlat_ack,
  output logic [31:0] xlat_paddr,
  output logic xlat_refill,
  output logic xlat_invalid,
  output logic [1:0] xlat_seg_mode,
  output logic xlat_kernel_fault,
  output logic cacheability_attribute_coherent,
  // Cache arrays
  input wire logic cache_req,
  output logic cache_ack,
  output logic cache_err,
  output logic cache_bus_err,
  output logic cache_line_valid,
  output logic cache_line_dirty,
  output logic [31:0] cache_tag_addr,
  // Writeback bus
  input wire logic wb_req,
  output logic wb_ack,
  output logic wb_err
);
  logic [2:0] rq, ak;
  int cnt [3];

  assign rq = {wb_req, cache_req, xlat_req};
  assign {wb_ack, cache_ack, xlat_ack} = ak;
  // Slow mode makes every answer wait three cycles
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ak <= 3'h0;
      cnt <= '{0, 0, 0};
    end else begin
      for (int k = 0; k < 3; k++) begin
        ak[k] <= rq[k] && !ak[k] && cnt[k] >= (flt[9] ? 3 : 0);
        cnt[k] <= (rq[k] && !ak[k]) ? cnt[k] + 1 : 0;
      end
    end
  end
  // Outside an answer the data lines carry junk, not the last value
  assign xlat_paddr = xlat_ack ? xlat_vaddr ^ 32'h4000_0000 : ~xlat_vaddr;
  assign cache_tag_addr = cache_ack ? TAG : ~TAG;
  assign xlat_refill = flt[0];
  assign xlat_invalid = flt[1];
  assign xlat_seg_mode = flt[2] ? 2'h0 : 2'h3;
  assign xlat_kernel_fault = flt[3];
  assign cache_line_valid = 1'b1;
  assign cache_line_dirty = flt[4];
  assign cache_err = flt[5];
  assign cache_bus_err = flt[6];
  assign wb_err = flt[7];
  assign cacheability_attribute_coherent = flt[8];
endmodule : ucmo_far_model

/* tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end end
module tb_top
  import ucmo_pkg::*;
;
  localparam logic [31:0] TAG = 32'h0012_34C0;
  logic clk, nrst, req_valid, req_ready, extended_vaddr_config_field;
  logic system_control_coprocessor_en, done, exc_valid, xlat_req;
  logic load_translation_cause, load_address_error_cause, wb_req, wb_ack;
  logic store_translation_cause, xlat_user_map, xlat_ack, xlat_refill;
  logic xlat_invalid, xlat_kernel_fault, cacheability_attribute_coherent;
  logic cache_req, cache_bcast, cache_ack, cache_err, cache_bus_err;
  logic cache_line_valid, cache_line_dirty, wb_err, bc, um;
  logic [2:0] req_op, cache_op, cache_way, lway, lop;
  logic [1:0] req_cache, xlat_seg_mode, cache_sel, lsel, fsel;
  logic [8:0] req_offset;
  logic [9:0] flt;
  logic [13:0] cache_index, lidx;
  logic [31:0] req_base, xlat_vaddr, xlat_paddr, cache_addr, wb_addr;
  logic [31:0] cache_tag_addr, va, la, wa;
  ucmo_exc_type exc_kind;
  ucmo_cmd_type cache_cmd, lcmd;
  int error_cnt = 0, n_checks = 0, nlev, nwb, nis, nbc;
  int ob [4] = '{5, 5, 6, 6};
  int ib [4] = '{13, 13, 17, 18};
  localparam int WBT [4] = '{2, 0, 3, 3};

  // Virtual I cache and direct-mapped D cache, so both paths get used
  ucmo_cache_op #(.VIRT_MASK(4'h1), .WAY_BITS(WBT)) dut_u (.clk, .nrst,
    .req_valid, .req_ready, .req_op,
    .req_cache, .req_base, .req_offset, .extended_vaddr_config_field,
    .system_control_coprocessor_en, .done, .exc_valid, .exc_kind,
    .load_translation_cause, .load_address_error_cause,
    .store_translation_cause, .xlat_req, .xlat_user_map, .xlat_vaddr,
    .xlat_ack, .xlat_paddr, .xlat_refill, .xlat_invalid, .xlat_seg_mode,
    .xlat_kernel_fault, .cacheability_attribute_coherent, .cache_req,
    .cache_cmd, .cache_sel, .cache_op, .cache_way, .cache_index,
    .cache_addr, .cache_bcast, .cache_ack, .cache_err, .cache_bus_err,
    .cache_line_valid, .cache_line_dirty, .cache_tag_addr, .wb_req,
    .wb_addr, .wb_ack, .wb_err);
  ucmo_far_model #(.TAG(TAG)) far_u (.clk, .nrst, .flt, .xlat_req,
    .xlat_vaddr, .xlat_ack, .xlat_paddr, .xlat_refill, .xlat_invalid,
    .xlat_seg_mode, .xlat_kernel_fault, .cacheability_attribute_coherent,
    .cache_req, .cache_ack, .cache_err, .cache_bus_err, .cache_line_valid,
    .cache_line_dirty, .cache_tag_addr, .wb_req, .wb_ack, .wb_err);

  always #4 clk = ~clk;
  // Capture what the design shows the caches and the bus
  always @(posedge clk) begin
    if (xlat_req) begin
      va = xlat_vaddr;
      um = xlat_user_map;
    end
    if (cache_req) la = cache_addr;
    if (cache_req && cache_bcast) bc = 1'b1;
    if (cache_req && cache_ack && cache_cmd != CMD_READ_TAG) begin
      lop = cache_op;
      lcmd = cache_cmd;
      nis++;
      if (cache_bcast) nbc++;
    end
    if (cache_req && cache_ack && cache_cmd == CMD_READ_TAG) begin
      if (nlev == 0) fsel = cache_sel;
      {lsel, lway, lidx} = {cache_sel, cache_way, cache_index};
      nlev++;
    end
    if (wb_req && wb_ack) begin
      nwb++;
      wa = wb_addr;
    end
  end

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  task automatic run(input logic [2:0] op, input logic [1:0] cs,
      input logic [31:0] b, input logic [8:0] o, input logic [1:0] cfg,
      input logic [9:0] f, input ucmo_exc_type ek);
    int i;
    logic [31:0] ea;
    ea = b + {{23{o[8]}}, o};
    flt = f;
    {extended_vaddr_config_field, system_control_coprocessor_en} = cfg;
    {nlev, nwb, nis, nbc, bc} = '0;
    {req_op, req_cache, req_base, req_offset} = {op, cs, b, o};
    req_valid = 1'b1;
    `CHK("ready", 1'b1, req_ready)
    @(posedge clk);
    #1 req_valid = 1'b0;
    i = 0;
    while (done !== 1'b1 && i < 300) begin
      @(posedge clk);
      #1 i++;
    end
    if (i == 300) begin
      error_cnt++;
      close_out();
    end
    `CHK("kind", ek, exc_kind)
    `CHK("exc", ek != EXC_NONE, exc_valid)
    `CHK("ld_xlat", ek inside {EXC_TRANS_REFILL, EXC_TRANS_INVALID},
      load_translation_cause)
    `CHK("ld_ae", ek == EXC_ADDR_ERR, load_address_error_cause)
    `CHK("st_xlat", 1'b0, store_translation_cause)
    if (ek inside {[EXC_TRANS_REFILL:EXC_ADDR_ERR]})
      `CHK("abort", 0, nlev)
    if (ek == EXC_NONE) begin
      `CHK("ea", ea, va)
      `CHK("umap", 1'b1, um)
      `CHK("op", op, lop)
      `CHK("cmd", op == OP_IDX_INV ? CMD_INVALIDATE : CMD_PASS_OP,
        lcmd)
    end
    if (ek == EXC_NONE && op == OP_IDX_INV) begin
      `CHK("sel", cs, lsel)
      `CHK("idx", 14'((ea >> ob[cs]) & ((1 << (ib[cs] - ob[cs])) - 1)),
        lidx)
      `CHK("way", 3'((ea >> ib[cs]) & ((1 << WBT[cs]) - 1)), lway)
    end
    @(posedge clk);
    #1;
  endtask : run

  initial begin
    {clk, nrst, req_valid, req_op, req_cache, req_base, req_offset} = '0;
    {extended_vaddr_config_field, system_control_coprocessor_en} = 2'h3;
    flt = 10'h000;
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    // Index bases sit in the unmapped region, the first and third on odd bytes on purpose
    run(3'h0, 2'h1, 32'h8000_1003, 9'h1FC, 2'h3, 10'h000, EXC_NONE);
    run(3'h0, 2'h3, 32'h80A5_5A40, 9'h040, 2'h3, 10'h210, EXC_NONE);
    `CHK("lev_s", 2, nlev)
    `CHK("first", 2'h1, fsel)
    `CHK("nwb", 2, nwb)
    `CHK("wbad", TAG, wa)
    run(3'h0, 2'h2, 32'h8123_4567, 9'h0FF, 2'h3, 10'h000, EXC_NONE);
    `CHK("lev_t", 3, nlev)
    run(3'h0, 2'h1, 32'h0040_0000, 9'h000, 2'h3, 10'h001,
      EXC_TRANS_REFILL);
    run(3'h0, 2'h1, 32'h0040_0000, 9'h000, 2'h3, 10'h202,
      EXC_TRANS_INVALID);
    run(3'h0, 2'h1, 32'hC000_0000, 9'h000, 2'h3, 10'h004,
      EXC_COP_UNUSABLE);
    run(3'h0, 2'h1, 32'hC000_0000, 9'h000, 2'h3, 10'h008,
      EXC_ADDR_ERR);
    run(3'h0, 2'h1, 32'h8000_0000, 9'h000, 2'h1, 10'h000,
      EXC_RESERVED_INSTR);
    run(3'h0, 2'h1, 32'h8000_0000, 9'h000, 2'h2, 10'h000,
      EXC_COP_UNUSABLE);
    run(3'h0, 2'h1, 32'h8000_0100, 9'h000, 2'h3, 10'h090,
      EXC_CACHE_ERR);
    run(3'h0, 2'h1, 32'h8000_0100, 9'h000, 2'h3, 10'h020,
      EXC_CACHE_ERR);
    run(3'h1, 2'h1, 32'h8000_0100, 9'h000, 2'h3, 10'h020, EXC_NONE);
    run(3'h2, 2'h3, 32'h8000_0100, 9'h000, 2'h3, 10'h220, EXC_NONE);
    run(3'h4, 2'h1, 32'h0001_2344, 9'h1F0, 2'h3, 10'h040,
      EXC_BUS_ERR);
    run(3'h4, 2'h1, 32'h0001_2344, 9'h010, 2'h3, 10'h100, EXC_NONE);
    `CHK("bcast", 1'b1, bc)
    `CHK("paddr", 32'h4001_2354, la)
    run(3'h4, 2'h3, 32'h0001_2344, 9'h010, 2'h3, 10'h000, EXC_NONE);
    `CHK("nobcast", 1'b0, bc)
    `CHK("nobc_lev", 0, nbc)
    run(3'h5, 2'h3, 32'h0001_2344, 9'h010, 2'h3, 10'h100, EXC_NONE);
    `CHK("bc_lev", 2, nbc)
    `CHK("n_lev", 2, nis)
    run(3'h4, 2'h0, 32'h0001_2344, 9'h010, 2'h3, 10'h000, EXC_NONE);
    `CHK("vaddr", 32'h0001_2354, la)
    close_out();
  end
endmodule : tb_top
